// ===== shared/cbo_map.svh
// encodings, field values and limits for the barrier ordering master
`ifndef CBO_MAP_SVH
`define CBO_MAP_SVH

// ************************************************************
// shareability domain codes
// ************************************************************
`define CBO_DOM_NSH        2'h0
`define CBO_DOM_INNER      2'h1
`define CBO_DOM_OUTER      2'h2
`define CBO_DOM_SYS        2'h3

// ************************************************************
// barrier indication field
// ************************************************************
`define CBO_BAR_NORMAL     2'h0
`define CBO_BAR_MEM        2'h1
`define CBO_BAR_SYNC       2'h3

// ************************************************************
// transaction type and cache attribute values
// ************************************************************
`define CBO_SNOOP_PLAIN    4'h0
`define CBO_SNOOP_DVM      4'hF
`define CBO_BAR_CACHE      4'h2
`define CBO_DVM_CACHE      4'h2
`define CBO_SYS_CACHE_KEEP 4'h3

// ************************************************************
// maintenance message operation field in the address
// ************************************************************
`define CBO_DVM_OP_LSB     12
`define CBO_DVM_OP_W       3
`define CBO_DVM_OP_TLBI    3'h0
`define CBO_DVM_OP_SYNC    3'h4

// ************************************************************
// limits
// ************************************************************
`define CBO_MAX_OUTST      8
`define CBO_ADDR_W         32

`endif

// ===== shared/cbo_pkg.sv
// types shared by the barrier ordering master
package cbo_pkg;

   typedef enum logic [2:0] {
      KIND_READ    = 3'h0,
      KIND_WRITE   = 3'h1,
      KIND_MEMBAR  = 3'h2,
      KIND_SYNCBAR = 3'h3,
      KIND_TLBI    = 3'h4,
      KIND_DVMSYNC = 3'h5
   } cbo_kind_e;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_DRAIN = 2'b01,
      ST_WAIT  = 2'b11
   } cbo_state_e;

endpackage

// ===== hw/cbo_addr_slot.sv
// one-entry holding register for an address channel
`timescale 1ns/1ps
module cbo_addr_slot #(
   parameter int W = 8
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         load,
   input  wire logic [W-1:0] load_data,
   input  wire logic         ready,
   output logic              valid,
   output logic [W-1:0]      data
);
   logic         valid_r;
   logic         valid_nxt;
   logic [W-1:0] data_r;
   logic [W-1:0] data_nxt;

   initial begin
      if (W < 1) begin
         $error("cbo_addr_slot: W must be at least 1");
      end
   end

   // owner only loads while the slot is empty
   always_comb begin
      valid_nxt = load | (valid_r & ~ready);
      data_nxt  = load ? load_data : data_r;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         valid_r <= 1'b0;
         data_r  <= '0;
      end else begin
         valid_r <= valid_nxt;
         data_r  <= data_nxt;
      end
   end

   assign valid = valid_r;
   assign data  = data_r;

   slot_hold_a: assert property (@(posedge clk) disable iff (rst)
      valid_r && !ready |=> valid_r && $stable(data_r))
      else $error("address slot dropped or changed before handshake");

endmodule

// ===== hw/cbo_master.sv
// barrier, domain and maintenance ordering for a coherent bus master
// Behaviour
// [RQ1] domain membership seen identically by all masters
// [RQ2] domains never overlap; outer holds whole inners
// [RQ3] system domain accesses never cached anywhere
// [RQ4] after barrier, older transactions observable first
// [RQ5] sync barrier completes once all earlier observable
// [RQ6] system sync waits for slaves to finish
// [RQ7] barrier has address and response, no data
// [RQ8] barrier issued on both address channels
// [RQ9] dependent traffic waits for both barrier responses
// [RQ10] tlb invalidate followed by maintenance sync
// [RQ11] attribute mismatch never deadlocks, always progresses
// [RQ12] mismatch corruption stays inside its 4KB region
// [RQ13] peripheral keeps answering despite modifiable accesses
// [RQ14] hardware protocol errors need no recovery
// [RQ15] two-bit barrier field driven with address
// [RQ16] blocking flag from barrier issue to responses
`timescale 1ns/1ps
`include "cbo_map.svh"
module cbo_master #(
   parameter int ADDR_W    = `CBO_ADDR_W,
   parameter int MAX_OUTST = `CBO_MAX_OUTST
) (
   input  wire logic              MCLK,
   input  wire logic              SYS_RST,
   input  wire logic              REQ_VALID,
   output logic                   REQ_READY,
   input  wire cbo_pkg::cbo_kind_e REQ_KIND,
   input  wire logic [ADDR_W-1:0] REQ_ADDR,
   input  wire logic [1:0]        REQ_DOMAIN,
   input  wire logic [3:0]        REQ_CACHE,
   output logic                   ARVALID,
   input  wire logic              ARREADY,
   output logic [ADDR_W-1:0]      ARADDR,
   output logic [1:0]             ARDOMAIN,
   output logic [1:0]             ARBAR,
   output logic [3:0]             ARCACHE,
   output logic [3:0]             ARSNOOP,
   output logic                   AWVALID,
   input  wire logic              AWREADY,
   output logic [ADDR_W-1:0]      AWADDR,
   output logic [1:0]             AWDOMAIN,
   output logic [1:0]             AWBAR,
   output logic [3:0]             AWCACHE,
   input  wire logic              RVALID,
   input  wire logic              RLAST,
   output logic                   RREADY,
   input  wire logic              BVALID,
   output logic                   BREADY,
   output logic                   BAR_DONE,
   output logic                   TLBI_PENDING
);
   import cbo_pkg::*;

   localparam int CW  = $clog2(MAX_OUTST + 1);
   localparam int ARW = ADDR_W + 12;
   localparam int AWW = ADDR_W + 8;

   initial begin
      if (MAX_OUTST < 1 || ADDR_W < `CBO_DVM_OP_LSB + `CBO_DVM_OP_W) begin
         $error("cbo_master: MAX_OUTST or ADDR_W out of range");
      end
   end

   // ************************************************************
   // helpers
   // ************************************************************
   function automatic logic is_bar(input cbo_kind_e k);
      is_bar = (k == KIND_MEMBAR) || (k == KIND_SYNCBAR);
   endfunction

   // [RQ3] strip allocation hints
   function automatic logic [3:0] dom_cache(input logic [1:0] d, input logic [3:0] c);
      dom_cache = (d == `CBO_DOM_SYS) ? (c & `CBO_SYS_CACHE_KEEP) : c;
   endfunction

   function automatic logic [ADDR_W-1:0] dvm_addr(input logic [ADDR_W-1:0] a,
                                                   input logic [`CBO_DVM_OP_W-1:0] op);
      logic [ADDR_W-1:0] t;
      t = a;
      t[`CBO_DVM_OP_LSB +: `CBO_DVM_OP_W] = op;
      dvm_addr = t;
   endfunction

   // ************************************************************
   // state
   // ************************************************************
   cbo_state_e        state_r;
   cbo_state_e        state_nxt;
   cbo_kind_e         kind_r;
   cbo_kind_e         kind_nxt;
   logic [1:0]        dom_r;
   logic [1:0]        dom_nxt;
   logic              got_r_r;
   logic              got_r_nxt;
   logic              got_b_r;
   logic              got_b_nxt;
   logic              done_r;
   logic              done_nxt;
   logic              tlbi_r;
   logic              tlbi_nxt;
   logic              ready_r;
   logic              ready_nxt;
   logic              rsp_rdy_r;
   logic [CW-1:0]     rd_cnt_r;
   logic [CW-1:0]     rd_cnt_nxt;
   logic [CW-1:0]     wr_cnt_r;
   logic [CW-1:0]     wr_cnt_nxt;
   logic              ar_load;
   logic              aw_load;
   logic [ARW-1:0]    ar_pay;
   logic [AWW-1:0]    aw_pay;
   logic [ARW-1:0]    ar_q;
   logic [AWW-1:0]    aw_q;
   logic              take;
   logic              r_end;
   logic              b_end;
   logic              rd_inc;
   logic              wr_inc;

   assign take  = REQ_VALID & ready_r;
   assign r_end = RVALID & rsp_rdy_r & RLAST;
   assign b_end = BVALID & rsp_rdy_r;

   // ************************************************************
   // sequencing
   // ************************************************************
   always_comb begin
      state_nxt = state_r;
      kind_nxt  = kind_r;
      dom_nxt   = dom_r;
      got_r_nxt = got_r_r;
      got_b_nxt = got_b_r;
      done_nxt  = 1'b0;
      tlbi_nxt  = tlbi_r;
      ar_load   = 1'b0;
      aw_load   = 1'b0;
      ar_pay    = '0;
      aw_pay    = '0;
      rd_inc    = 1'b0;
      wr_inc    = 1'b0;
      unique case (state_r)
         ST_IDLE: begin
            // [RQ1] domain passed as given, never remapped here
            // [RQ2] [RQ12] domain unaltered; address unaltered except the TLBI op bits
            if (take) begin
               unique case (REQ_KIND)
                  KIND_READ: begin
                     ar_load = 1'b1;
                     rd_inc  = 1'b1;
                     ar_pay  = {REQ_ADDR, REQ_DOMAIN, `CBO_BAR_NORMAL,
                                dom_cache(REQ_DOMAIN, REQ_CACHE), `CBO_SNOOP_PLAIN};
                  end
                  KIND_WRITE: begin
                     aw_load = 1'b1;
                     wr_inc  = 1'b1;
                     aw_pay  = {REQ_ADDR, REQ_DOMAIN, `CBO_BAR_NORMAL,
                                dom_cache(REQ_DOMAIN, REQ_CACHE)};
                  end
                  // [RQ10] invalidate left pending until a maintenance sync (KIND_DVMSYNC) completes
                  KIND_TLBI: begin
                     ar_load  = 1'b1;
                     rd_inc   = 1'b1;
                     tlbi_nxt = 1'b1;
                     ar_pay   = {dvm_addr(REQ_ADDR, `CBO_DVM_OP_TLBI), REQ_DOMAIN,
                                 `CBO_BAR_NORMAL, `CBO_DVM_CACHE, `CBO_SNOOP_DVM};
                  end
                  KIND_MEMBAR, KIND_SYNCBAR, KIND_DVMSYNC: begin
                     kind_nxt  = REQ_KIND;
                     dom_nxt   = REQ_DOMAIN;
                     state_nxt = ST_DRAIN;
                  end
                  // undefined kinds are dropped; no recovery attempted
                  default: begin
                     state_nxt = ST_IDLE;
                  end
               endcase
            end
         end
         ST_DRAIN: begin
            // [RQ4] older traffic fully answered before barrier leaves
            if (rd_cnt_r == '0 && wr_cnt_r == '0 && !ARVALID && !AWVALID) begin
               state_nxt = ST_WAIT;
               got_r_nxt = 1'b0;
               got_b_nxt = 1'b0;
               ar_load   = 1'b1;
               if (is_bar(kind_r)) begin
                  // [RQ8] same barrier on both channels, [RQ15] coded field
                  aw_load = 1'b1;
                  ar_pay  = {{ADDR_W{1'b0}}, dom_r,
                             (kind_r == KIND_SYNCBAR) ? `CBO_BAR_SYNC : `CBO_BAR_MEM,
                             `CBO_BAR_CACHE, `CBO_SNOOP_PLAIN};
                  aw_pay  = {{ADDR_W{1'b0}}, dom_r,
                             (kind_r == KIND_SYNCBAR) ? `CBO_BAR_SYNC : `CBO_BAR_MEM,
                             `CBO_BAR_CACHE};
               end else begin
                  ar_pay  = {dvm_addr({ADDR_W{1'b0}}, `CBO_DVM_OP_SYNC), dom_r,
                             `CBO_BAR_NORMAL, `CBO_DVM_CACHE, `CBO_SNOOP_DVM};
               end
            end
         end
         ST_WAIT: begin
            // [RQ7] a single response per channel ends the barrier, no data
            if (r_end) begin
               got_r_nxt = 1'b1;
            end
            if (b_end) begin
               got_b_nxt = 1'b1;
            end
            // [RQ5] completion only after every needed response; [RQ6] relied on
            if ((got_r_r | r_end) && (got_b_r | b_end | !is_bar(kind_r))) begin
               state_nxt = ST_IDLE;
               done_nxt  = 1'b1;
               if (kind_r == KIND_DVMSYNC) begin
                  tlbi_nxt = 1'b0;
               end
            end
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase

      // [RQ14] stray responses are absorbed, counts never wrap
      rd_cnt_nxt = rd_cnt_r;
      wr_cnt_nxt = wr_cnt_r;
      if (rd_inc) begin
         rd_cnt_nxt = rd_cnt_nxt + CW'(1);
      end
      if (r_end && state_r != ST_WAIT && rd_cnt_r != '0) begin
         rd_cnt_nxt = rd_cnt_nxt - CW'(1);
      end
      if (wr_inc) begin
         wr_cnt_nxt = wr_cnt_nxt + CW'(1);
      end
      if (b_end && state_r != ST_WAIT && wr_cnt_r != '0) begin
         wr_cnt_nxt = wr_cnt_nxt - CW'(1);
      end

      // [RQ9] [RQ16] the non-idle state is the blocking flag
      ready_nxt = (state_nxt == ST_IDLE) &&
                  !(ar_load | (ARVALID & ~ARREADY)) &&
                  !(aw_load | (AWVALID & ~AWREADY)) &&
                  (rd_cnt_nxt < CW'(MAX_OUTST)) && (wr_cnt_nxt < CW'(MAX_OUTST));
   end

   always_ff @(posedge MCLK) begin
      if (SYS_RST) begin
         state_r   <= ST_IDLE;
         kind_r    <= KIND_READ;
         dom_r     <= 2'h0;
         got_r_r   <= 1'b0;
         got_b_r   <= 1'b0;
         done_r    <= 1'b0;
         tlbi_r    <= 1'b0;
         ready_r   <= 1'b0;
         rsp_rdy_r <= 1'b0;
         rd_cnt_r  <= '0;
         wr_cnt_r  <= '0;
      end else begin
         state_r   <= state_nxt;
         kind_r    <= kind_nxt;
         dom_r     <= dom_nxt;
         got_r_r   <= got_r_nxt;
         got_b_r   <= got_b_nxt;
         done_r    <= done_nxt;
         tlbi_r    <= tlbi_nxt;
         ready_r   <= ready_nxt;
         rsp_rdy_r <= 1'b1;
         rd_cnt_r  <= rd_cnt_nxt;
         wr_cnt_r  <= wr_cnt_nxt;
      end
   end

   // ************************************************************
   // address channel slots
   // ************************************************************
   cbo_addr_slot #(.W(ARW)) u_ar_slot (
      .clk       (MCLK),
      .rst       (SYS_RST),
      .load      (ar_load),
      .load_data (ar_pay),
      .ready     (ARREADY),
      .valid     (ARVALID),
      .data      (ar_q)
   );

   cbo_addr_slot #(.W(AWW)) u_aw_slot (
      .clk       (MCLK),
      .rst       (SYS_RST),
      .load      (aw_load),
      .load_data (aw_pay),
      .ready     (AWREADY),
      .valid     (AWVALID),
      .data      (aw_q)
   );

   assign {ARADDR, ARDOMAIN, ARBAR, ARCACHE, ARSNOOP} = ar_q;
   assign {AWADDR, AWDOMAIN, AWBAR, AWCACHE}          = aw_q;
   assign REQ_READY    = ready_r;
   assign RREADY       = rsp_rdy_r;
   assign BREADY       = rsp_rdy_r;
   assign BAR_DONE     = done_r;
   assign TLBI_PENDING = tlbi_r;

   // ************************************************************
   // checks
   // ************************************************************
   ar_sys_nocache_a: assert property ( // [RQ3]
      @(posedge MCLK) disable iff (SYS_RST)
      ARVALID && ARDOMAIN == `CBO_DOM_SYS |-> ARCACHE[3:2] == 2'b00)
      else $error("system domain read carries allocate hints");

   aw_sys_nocache_a: assert property ( // [RQ3]
      @(posedge MCLK) disable iff (SYS_RST)
      AWVALID && AWDOMAIN == `CBO_DOM_SYS |-> AWCACHE[3:2] == 2'b00)
      else $error("system domain write carries allocate hints");

   bar_pair_a: assert property ( // [RQ8]
      @(posedge MCLK) disable iff (SYS_RST)
      $rose(ARVALID) && ARBAR != `CBO_BAR_NORMAL |-> $rose(AWVALID) && AWBAR == ARBAR)
      else $error("barrier not presented on both address channels");

   bar_drained_a: assert property ( // [RQ4]
      @(posedge MCLK) disable iff (SYS_RST)
      $rose(ARVALID) && ARBAR != `CBO_BAR_NORMAL |-> rd_cnt_r == '0 && wr_cnt_r == '0)
      else $error("barrier issued with older traffic outstanding");

   bar_block_a: assert property ( // [RQ9]
      @(posedge MCLK) disable iff (SYS_RST)
      state_r == ST_WAIT |-> !REQ_READY ##1 (state_r != ST_WAIT || !REQ_READY))
      else $error("request accepted while barrier responses outstanding");

   bar_done_a: assert property ( // [RQ5]
      @(posedge MCLK) disable iff (SYS_RST)
      BAR_DONE |-> $past(state_r) == ST_WAIT && state_r == ST_IDLE)
      else $error("barrier completion without both responses");

   bar_field_a: assert property ( // [RQ15]
      @(posedge MCLK) disable iff (SYS_RST)
      ARVALID && ARBAR != `CBO_BAR_NORMAL |-> ARADDR == '0 && ARSNOOP == `CBO_SNOOP_PLAIN
                                             && ARCACHE == `CBO_BAR_CACHE)
      else $error("barrier field with wrong companion attributes");

   drain_moves_a: assert property ( // [RQ11]
      @(posedge MCLK) disable iff (SYS_RST)
      state_r == ST_DRAIN && rd_cnt_r == '0 && wr_cnt_r == '0 && !ARVALID && !AWVALID
      |=> state_r == ST_WAIT && ARVALID)
      else $error("drained barrier failed to issue");

   tlbi_sync_a: assert property ( // [RQ10]
      @(posedge MCLK) disable iff (SYS_RST)
      BAR_DONE && $past(kind_r) == KIND_DVMSYNC |-> !TLBI_PENDING)
      else $error("maintenance sync left invalidate pending");

endmodule

// ===== dv/cbo_ic_model.sv
// behavioural interconnect that answers both address channels in order
`timescale 1ns/1ps
module cbo_ic_model (
   input  wire logic       MCLK,
   input  wire logic       SYS_RST,
   input  wire logic       slow,
   input  wire logic       ARVALID,
   input  wire logic [1:0] ARBAR,
   input  wire logic       AWVALID,
   input  wire logic       RREADY,
   input  wire logic       BREADY,
   output logic            ARREADY,
   output logic            AWREADY,
   output logic            RVALID,
   output logic            RLAST,
   output logic            BVALID,
   output int              pend
);
   int   rq[$];
   int   wq;
   int   seed_m = 4711;
   logic gate;

   always @(posedge MCLK) begin
      gate = slow ? 1'($random(seed_m) & 1) : 1'b1;
      if (SYS_RST) begin
         ARREADY <= 1'b0;
         AWREADY <= 1'b0;
         RVALID  <= 1'b0;
         RLAST   <= 1'b0;
         BVALID  <= 1'b0;
         rq.delete();
         wq = 0;
      end else begin
         // barrier read gets a lone response beat
         if (ARVALID && ARREADY) rq.push_back((ARBAR != 2'h0) ? 1 : 2);
         if (AWVALID && AWREADY) wq++;
         if (RVALID && RREADY) begin
            rq[0]--;
            if (rq[0] == 0) void'(rq.pop_front());
         end
         if (BVALID && BREADY) wq--;
         ARREADY <= gate;
         AWREADY <= slow ? 1'($random(seed_m) & 1) : 1'b1;
         // every request answered, strictly in order
         if (!RVALID || RREADY) begin
            if (rq.size() > 0 && gate) begin
               RVALID <= 1'b1;
               RLAST  <= (rq[0] == 1);
            end else begin
               // idle line toggles the last flag
               RVALID <= 1'b0;
               RLAST  <= ~RLAST;
            end
         end
         if (!BVALID || BREADY) BVALID <= (wq > 0) && gate;
      end
      pend = rq.size() + wq;
   end
endmodule

// ===== dv/tb_cbo_master.sv
// self-checking bench for the barrier ordering master
`timescale 1ns/1ps
`include "cbo_map.svh"
module tb_cbo_master;
   import cbo_pkg::*;
   logic MCLK, SYS_RST, REQ_VALID, REQ_READY, ARVALID, ARREADY, AWVALID, AWREADY;
   logic RVALID, RLAST, RREADY, BVALID, BREADY, BAR_DONE, TLBI_PENDING, slow;
   cbo_kind_e   REQ_KIND;
   logic [31:0] REQ_ADDR, ARADDR, AWADDR;
   logic [1:0]  REQ_DOMAIN, ARDOMAIN, AWDOMAIN, ARBAR, AWBAR;
   logic [3:0]  REQ_CACHE, ARCACHE, AWCACHE, ARSNOOP;
   logic [87:0] ar_q[$], aw_q[$], x;
   int          pend, done_exp, failures, checks, i, n;
   int          seed = 31765;
   logic        bar_open;

   cbo_master u_cbo_master (.MCLK(MCLK), .SYS_RST(SYS_RST), .REQ_VALID(REQ_VALID),
      .REQ_READY(REQ_READY), .REQ_KIND(REQ_KIND), .REQ_ADDR(REQ_ADDR),
      .REQ_DOMAIN(REQ_DOMAIN), .REQ_CACHE(REQ_CACHE), .ARVALID(ARVALID),
      .ARREADY(ARREADY), .ARADDR(ARADDR), .ARDOMAIN(ARDOMAIN), .ARBAR(ARBAR),
      .ARCACHE(ARCACHE), .ARSNOOP(ARSNOOP), .AWVALID(AWVALID), .AWREADY(AWREADY),
      .AWADDR(AWADDR), .AWDOMAIN(AWDOMAIN), .AWBAR(AWBAR), .AWCACHE(AWCACHE),
      .RVALID(RVALID), .RLAST(RLAST), .RREADY(RREADY), .BVALID(BVALID),
      .BREADY(BREADY), .BAR_DONE(BAR_DONE), .TLBI_PENDING(TLBI_PENDING));
   cbo_ic_model u_cbo_ic_model (.MCLK(MCLK), .SYS_RST(SYS_RST), .slow(slow),
      .ARVALID(ARVALID), .ARBAR(ARBAR), .AWVALID(AWVALID), .RREADY(RREADY),
      .BREADY(BREADY), .ARREADY(ARREADY), .AWREADY(AWREADY), .RVALID(RVALID),
      .RLAST(RLAST), .BVALID(BVALID), .pend(pend));

   initial begin
      MCLK = 1'b0;
      forever #5 MCLK = ~MCLK;
   end

   task automatic chk(input string name, input logic [43:0] seen, input logic [43:0] exp);
      checks++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // ************************************************************
   // request driver, notes what each channel must show
   // ************************************************************
   task automatic send(input logic [2:0] k, input logic [31:0] a, input logic [1:0] d,
                       input logic [3:0] c);
      logic [43:0] e;
      logic [3:0]  cc;
      @(posedge MCLK);
      REQ_VALID  <= 1'b1;
      REQ_KIND   <= cbo_kind_e'(k);
      REQ_ADDR   <= a;
      REQ_DOMAIN <= d;
      REQ_CACHE  <= c;
      cc = (d == `CBO_DOM_SYS) ? (c & 4'h3) : c;
      if (k == 3'h0) ar_q.push_back({44'hFFFFFFFFFFF, a, d, `CBO_BAR_NORMAL, cc, `CBO_SNOOP_PLAIN});
      if (k == 3'h1) aw_q.push_back({44'hFFFFFFFFFF0, a, d, `CBO_BAR_NORMAL, cc, 4'h0});
      // barrier pair, same field on both channels
      if (k == 3'h2 || k == 3'h3) begin
         e = {32'h0, d, (k == 3'h2) ? `CBO_BAR_MEM : `CBO_BAR_SYNC, `CBO_BAR_CACHE, 4'h0};
         ar_q.push_back({44'hFFFFFFFFFFF, e});
         aw_q.push_back({44'hFFFFFFFFFF0, e});
         done_exp++;
      end
      // maintenance messages carry their operation code
      if (k == 3'h4 || k == 3'h5) begin
         e = {d, `CBO_BAR_NORMAL, `CBO_DVM_CACHE, `CBO_SNOOP_DVM};
         e[26:24] = (k == 3'h4) ? `CBO_DVM_OP_TLBI : `CBO_DVM_OP_SYNC;
         ar_q.push_back({44'h00007000FFF, e});
         if (k == 3'h5) done_exp++;
      end
      n = 0;
      do begin
         @(negedge MCLK);
         n++;
      end while (REQ_READY !== 1'b1 && n < 3000);
      // a request never taken is a hang, not a pass
      if (REQ_READY !== 1'b1) begin
         failures++;
      end
      @(posedge MCLK);
      REQ_VALID <= 1'b0;
   endtask

   task automatic settle();
      n = 0;
      while ((ar_q.size() + aw_q.size() + done_exp + pend) != 0 && n < 3000) begin
         @(negedge MCLK);
         n++;
      end
      if ((ar_q.size() + aw_q.size() + done_exp + pend) != 0) begin
         failures++;
      end
      repeat (2) @(posedge MCLK);
   endtask

   // ************************************************************
   // output monitor
   // ************************************************************
   always @(negedge MCLK) begin
      if (!SYS_RST) begin
         if (BAR_DONE === 1'b1) begin
            chk("done_pulse", 44'(done_exp > 0), 44'h1);
            done_exp--;
            bar_open = 1'b0;
         end
         // no take while barrier responses pending
         if (bar_open) chk("req_blocked", 44'(REQ_READY), 44'h0);
         if (ARVALID === 1'b1 && ARREADY === 1'b1) begin
            if (ARBAR != 2'h0) begin
               if (!bar_open) chk("drained_ar", 44'(pend), 44'h0);
               bar_open = 1'b1;
            end else chk("ar_held", 44'(bar_open), 44'h0);
            if (ar_q.size() == 0) chk("ar_extra", 44'h1, 44'h0);
            else begin
               x = ar_q.pop_front();
               chk("ar", {ARADDR, ARDOMAIN, ARBAR, ARCACHE, ARSNOOP} & x[87:44], x[43:0]);
            end
         end
         if (AWVALID === 1'b1 && AWREADY === 1'b1) begin
            if (AWBAR != 2'h0) begin
               if (!bar_open) chk("drained_aw", 44'(pend), 44'h0);
               bar_open = 1'b1;
            end else chk("aw_held", 44'(bar_open), 44'h0);
            if (aw_q.size() == 0) chk("aw_extra", 44'h1, 44'h0);
            else begin
               x = aw_q.pop_front();
               chk("aw", {AWADDR, AWDOMAIN, AWBAR, AWCACHE, 4'h0} & x[87:44], x[43:0]);
            end
         end
      end
   end

   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      REQ_VALID  = 1'b0;
      REQ_KIND   = KIND_READ;
      REQ_ADDR   = 32'h0;
      REQ_DOMAIN = 2'h0;
      REQ_CACHE  = 4'h0;
      SYS_RST    = 1'b1;
      slow       = 1'b0;
      bar_open   = 1'b0;
      repeat (6) @(posedge MCLK);
      SYS_RST <= 1'b0;
      repeat (2) @(posedge MCLK);
      for (i = 0; i < 24; i++) send(3'($random(seed) & 1), $random(seed), 2'(i), $random(seed));
      // stalls, plus traffic in front of every barrier so each must drain
      slow <= 1'b1;
      for (i = 0; i < 8; i++) begin
         send(3'h0, $random(seed), 2'(i), $random(seed));
         send(3'h1, $random(seed), 2'(i), $random(seed));
         send(3'(2 + i % 2), $random(seed), 2'(i / 2), $random(seed));
      end
      settle();
      slow <= 1'b0;
      send(3'h4, $random(seed), 2'h1, 4'h0);
      settle();
      chk("tlbi_set", 44'(TLBI_PENDING), 44'h1);
      send(3'h5, $random(seed), 2'h1, 4'h0);
      settle();
      chk("tlbi_clear", 44'(TLBI_PENDING), 44'h0);
      send(3'h6, $random(seed), 2'h0, 4'h0);
      send(3'h7, $random(seed), 2'h0, 4'h0);
      settle();
      chk("queues_empty", 44'(ar_q.size() + aw_q.size() + done_exp), 44'h0);
      chk("rsp_ready", 44'({RREADY, BREADY}), 44'h3);
      wrap_up();
   end

   initial begin
      repeat (60000) @(posedge MCLK);
      failures++;
      wrap_up();
   end
endmodule
